// ### pad_pullup_and_pin_defaults_bench.sv
// Purpose: directed bench for pcmx_top
// Assumes: bus task waits on pready
// Notes: full part first, reduced part last
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
  num_errors++; $display("BAD %s exp %h seen %h", n, e, a); end end
module pad_pullup_and_pin_defaults_bench;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fv = 1, ctx = 1, t0e = 0, s0t = 1;
  reg [31:0] paddr = 0, pwdata = 0, rd;
  reg [3:0] pad_i = 4'hc;
  reg er;
  wire [31:0] prdata;
  wire pready, pslverr, crx, t0i, t1i, s0r;
  wire [3:0] pad_o, pad_oe, pu;
  integer num_errors = 0, tests_run = 0, cyc = 0;
  always #10 pclk = ~pclk;
  pcmx_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .full_variant(fv), .can_tx_data(ctx), .can_rx_data(crx), .timer_c_ch0_o(1'b1),
    .timer_c_ch0_oe(t0e), .timer_c_ch0_i(t0i), .timer_c_ch1_o(1'b0), .timer_c_ch1_oe(t0e),
    .timer_c_ch1_i(t1i), .serial0_transmit(s0t), .serial0_receive(s0r), .pad_i, .pad_o,
    .pad_oe, .pad_pullup(pu));
  task bus(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
    end
  endtask
  task rst(input v);
    begin
      @(posedge pclk);
      presetn <= 1'b0;
      fv <= v;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
    end
  endtask
  task t_full;
    begin
      rst(1'b1);
      `CHK("pu", 4'hf, pu)
      `CHK("rx", 1'b0, crx)
      `CHK("tc0", 1'b1, t0i)
      `CHK("tc1", 1'b1, t1i)
      @(posedge pclk);
      ctx <= 1'b0;
      t0e <= 1'b1;
      @(negedge pclk);
      `CHK("od_low", 3'h4, {pad_oe[1], pad_o[1], pu[1]})
      `CHK("tc_drv", 5'h18, {pad_oe[3:2], pad_o[3], pu[3:2]})
      bus(1'b1, 32'h4, 32'hd);
      @(posedge pclk);
      ctx <= 1'b1;
      bus(1'b1, 32'h0, 32'h0);
      `CHK("od_cut", 2'h0, {pad_oe[1], pu[1]})
      bus(1'b1, 32'h4, 32'hf);
      `CHK("od_hi", 2'h1, {pad_oe[1], pu[1]})
      @(posedge pclk);
      t0e <= 1'b0;
      pad_i <= 4'h4;
      $display("done t_full");
    end
  endtask
  task t_mux;
    begin
      bus(1'b1, 32'h0, 32'h50);
      `CHK("s0tx", 3'h6, {pad_oe[2], pad_o[2], pu[2]})
      `CHK("s0rx", 2'h0, {s0r, pad_oe[3]})
      bus(1'b1, 32'h0, 32'ha0);
      bus(1'b1, 32'h8, 32'h8);
      bus(1'b1, 32'hc, 32'hc);
      `CHK("g3", 9'h117, {pad_oe, pad_o[3], pu})
      bus(1'b1, 32'h8, 32'h4);
      `CHK("g2", 9'h09b, {pad_oe, pad_o[2], pu})
      bus(1'b0, 32'hc, 32'h0);
      `CHK("lvl", pad_i, rd[3:0])
      bus(1'b0, 32'h10, 32'h0);
      `CHK("unmapped", 1'b1, er)
      `CHK("unmapped_rd", 32'h0, rd)
      $display("done t_mux");
    end
  endtask
  task t_red;
    begin
      rst(1'b0);
      `CHK("red", 3'h1, {pad_oe[1:0], crx})
      bus(1'b0, 32'h0, 32'h0);
      `CHK("fsel", 8'h0f, rd[7:0])
      $display("done t_red");
    end
  endtask
  task conclude;
    begin
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    t_full;
    t_mux;
    t_red;
    conclude;
  end
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      conclude;
    end
  end
endmodule

// ### pcmx_pad.v
// Purpose: one pad's pull-up and drive decision
// Assumes: open-drain pads never drive high
// Notes: pull-up only meaningful when not actively pulling low
`timescale 1ns/1ps
module pcmx_pad (
  input wire oe,
  input wire od,
  input wire level,
  input wire pu_en,
  output wire pad_o,
  output wire pad_oe,
  output wire pu_on
);
  // open drain: drive only low, release for high
  assign pad_oe = oe & (~od | ~level);
  assign pad_o = od ? 1'b0 : level;
  // inputs keep the software pull-up setting
  assign pu_on = ~oe ? pu_en :
                  ~od ? 1'b0 :
                  ~level ? 1'b0 :
                  pu_en;
endmodule

// ### pcmx_regs.vh
// Purpose: register map and constants for the port c pad/function mux
// Assumes: apb, 32-bit data, word-aligned registers
// Notes: pin order is can_rx, can_tx, timer_c_ch0, timer_c_ch1
`ifndef PCMX_REGS_VH
`define PCMX_REGS_VH
`define PCMX_NPINS 4
`define PCMX_ADDR_W 4
`define PCMX_OFF_FSEL 4'h0
`define PCMX_OFF_PULLUP_ENABLE_REG 4'h4
`define PCMX_OFF_DDR 4'h8
`define PCMX_OFF_DOUT 4'hc
`define PCMX_FSEL_W 8
`define PCMX_FSEL_PERIPH 2'h0
`define PCMX_FSEL_ALT 2'h1
`define PCMX_FSEL_GPIO 2'h2
`define PCMX_FSEL_NONE 2'h3
`define PCMX_FSEL_RST_FULL 8'h00
`define PCMX_FSEL_RST_RED 8'h0f
`define PCMX_PULLUP_ENABLE_REG_RST 4'hf
`define PCMX_DDR_RST 4'h0
`define PCMX_DOUT_RST 4'h0
`define PCMX_OD_MASK 4'h2
`endif

// ### pcmx_sel.v
// Purpose: per-pin function decode from a 2-bit select
// Assumes: select codes from pcmx_regs.vh
// Notes: code none leaves the pin inert
`timescale 1ns/1ps
`include "pcmx_regs.vh"
module pcmx_sel (
  input wire [1:0] sel,
  output wire is_periph,
  output wire is_alt,
  output wire is_gpio
);
  assign is_periph = (sel == `PCMX_FSEL_PERIPH);
  assign is_alt = (sel == `PCMX_FSEL_ALT);
  assign is_gpio = (sel == `PCMX_FSEL_GPIO);
endmodule

// ### pcmx_top.v
// Purpose: port c pad control for can rx/tx and timer c channel 0/1 pins
// Assumes: apb slave, single clock, peripheral signals synchronous to pclk
// Notes: full_variant strap is sampled on the first pclk edge after reset release
// Contract
// - an open-drain output driving low has its pull-up forced off.
// - an open-drain output driving high keeps its pull-up unless its enable bit is clear.
// - a push-pull output has its pull-up off at either level.
// - can rx is an input with pull-up, default can receive on full part and none on the reduced part, selectable as port c line 2.
// - can tx is open-drain with pull-up at reset, default can transmit on full part and none on the reduced part, selectable as line 3.
// - timer c ch0 pin defaults to timer, selectable as serial 0 transmit or port c line 6.
// - timer c ch1 pin defaults to timer, selectable as serial 0 receive or port c line 5.
// - on the reduced part the can pins leave reset in none of their functions.
// - each pin in port function is independently programmable as input or output.
`timescale 1ns/1ps
`include "pcmx_regs.vh"
module pcmx_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire full_variant,
  input wire can_tx_data,
  output wire can_rx_data,
  input wire timer_c_ch0_o,
  input wire timer_c_ch0_oe,
  output wire timer_c_ch0_i,
  input wire timer_c_ch1_o,
  input wire timer_c_ch1_oe,
  output wire timer_c_ch1_i,
  input wire serial0_transmit,
  output wire serial0_receive,
  input wire [3:0] pad_i,
  output wire [3:0] pad_o,
  output wire [3:0] pad_oe,
  output wire [3:0] pad_pullup
);
  localparam NP = `PCMX_NPINS;
  reg [`PCMX_FSEL_W-1:0] fsel_q;
  reg [NP-1:0] pullup_enable_reg_q;
  reg [NP-1:0] ddr_q;
  reg [NP-1:0] dout_q;
  reg [NP-1:0] od_q;
  reg init_q;
  wire [NP-1:0] is_p;
  wire [NP-1:0] is_a;
  wire [NP-1:0] is_g;
  reg [NP-1:0] oe_c;
  reg [NP-1:0] lvl_c;
  reg [NP-1:0] odm_c;
  wire [3:0] off;
  wire wr;
  wire rd;
  wire mapped;

  assign off = paddr[`PCMX_ADDR_W-1:0];
  assign mapped = (paddr[31:`PCMX_ADDR_W] == 28'h0000000);
  assign wr = psel & penable & pwrite & mapped;
  assign rd = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // open-drain marks for the pads; can tx is fixed open drain
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      od_q <= `PCMX_OD_MASK;
    end else begin
      od_q <= `PCMX_OD_MASK;
    end
  end

  // the strap cannot feed the async reset, so it is applied one edge after release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_q <= 1'b1;
      fsel_q <= `PCMX_FSEL_RST_FULL;
      pullup_enable_reg_q <= `PCMX_PULLUP_ENABLE_REG_RST;
      ddr_q <= `PCMX_DDR_RST;
      dout_q <= `PCMX_DOUT_RST;
    end else begin
      init_q <= 1'b0;
      if (init_q) begin
        if (!full_variant)
          fsel_q <= `PCMX_FSEL_RST_RED;
      end else if (wr) begin
        case (off)
          `PCMX_OFF_FSEL: fsel_q <= pwdata[`PCMX_FSEL_W-1:0];
          `PCMX_OFF_PULLUP_ENABLE_REG: pullup_enable_reg_q <= pwdata[NP-1:0];
          `PCMX_OFF_DDR: ddr_q <= pwdata[NP-1:0];
          `PCMX_OFF_DOUT: dout_q <= pwdata[NP-1:0];
          default: ;
        endcase
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd & ~mapped) begin
      // refused reads give zero, not an alias of the low offsets
      prdata <= 32'h00000000;
    end else if (rd) begin
      case (off)
        `PCMX_OFF_FSEL: prdata <= {24'h000000, fsel_q};
        `PCMX_OFF_PULLUP_ENABLE_REG: prdata <= {28'h0000000, pullup_enable_reg_q};
        `PCMX_OFF_DDR: prdata <= {28'h0000000, ddr_q};
        `PCMX_OFF_DOUT: prdata <= {28'h0000000, pad_i};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1) begin : pin
      pcmx_sel u_sel (
        .sel(fsel_q[2*g+1:2*g]),
        .is_periph(is_p[g]),
        .is_alt(is_a[g]),
        .is_gpio(is_g[g])
      );
      pcmx_pad u_pad (
        .oe(oe_c[g]),
        .od(odm_c[g]),
        .level(lvl_c[g]),
        .pu_en(pullup_enable_reg_q[g]),
        .pad_o(pad_o[g]),
        .pad_oe(pad_oe[g]),
        .pu_on(pad_pullup[g])
      );
    end
  endgenerate

  // port function (sel alt on can pins or gpio on any pin) uses ddr/dout
  always @* begin
    oe_c = 4'h0;
    lvl_c = 4'h0;
    odm_c = 4'h0;
    // can rx: receive input
    if (is_a[0] | is_g[0]) begin
      oe_c[0] = ddr_q[0];
      lvl_c[0] = dout_q[0];
    end
    // can tx: open drain transmit
    if (is_p[1]) begin
      oe_c[1] = 1'b1;
      lvl_c[1] = can_tx_data;
      odm_c[1] = od_q[1];
    end else if (is_a[1] | is_g[1]) begin
      oe_c[1] = ddr_q[1];
      lvl_c[1] = dout_q[1];
    end
    // timer c ch0 / serial 0 transmit / line 6
    if (is_p[2]) begin
      oe_c[2] = timer_c_ch0_oe;
      lvl_c[2] = timer_c_ch0_o;
    end else if (is_a[2]) begin
      oe_c[2] = 1'b1;
      lvl_c[2] = serial0_transmit;
    end else if (is_g[2]) begin
      oe_c[2] = ddr_q[2];
      lvl_c[2] = dout_q[2];
    end
    // timer c ch1 / serial 0 receive / line 5
    if (is_p[3]) begin
      oe_c[3] = timer_c_ch1_oe;
      lvl_c[3] = timer_c_ch1_o;
    end else if (is_g[3]) begin
      oe_c[3] = ddr_q[3];
      lvl_c[3] = dout_q[3];
    end
  end

  // can rx and serial 0 receive idle high, timer c inputs idle low, when the pin is not routed to that function
  assign can_rx_data = is_p[0] ? pad_i[0] : 1'b1;
  assign timer_c_ch0_i = is_p[2] ? pad_i[2] : 1'b0;
  assign timer_c_ch1_i = is_p[3] ? pad_i[3] : 1'b0;
  assign serial0_receive = is_a[3] ? pad_i[3] : 1'b1;
endmodule

// ### pcmx_top_properties.sv
// Purpose: port checks for pcmx_top
// Assumes: pull-up enable shadowed from bus writes
// Notes: fsel writes judged one cycle later
`timescale 1ns/1ps
module pcmx_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire full_variant,
  input wire can_tx_data,
  input wire can_rx_data,
  input wire timer_c_ch0_oe,
  input wire serial0_transmit,
  input wire serial0_receive,
  input wire [3:0] pad_i,
  input wire [3:0] pad_o,
  input wire [3:0] pad_oe,
  input wire [3:0] pad_pullup
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite;
  wire fw = wr && paddr == 32'h0;
  reg [3:0] pu_q;
  always @(posedge pclk or negedge presetn)
    if (!presetn) pu_q <= 4'hf;
    else if (wr && paddr == 32'h4) pu_q <= pwdata[3:0];
  property p_drv; (pad_oe & pad_pullup) == 4'h0; endproperty
  a_drv: assert property (p_drv) else $error("pull-up on driven pad");
  property p_idle; (pad_pullup & ~pad_oe) == (pu_q & ~pad_oe); endproperty
  a_idle: assert property (p_idle) else $error("idle pull-up wrong");
  property p_rx; fw && pwdata[1:0] == 2'h0 |=> can_rx_data == pad_i[0] && !pad_oe[0]; endproperty
  a_rx: assert property (p_rx) else $error("can rx path");
  property p_tx; fw && pwdata[3:2] == 2'h0 |=> !pad_o[1] && pad_oe[1] == !can_tx_data; endproperty
  a_tx: assert property (p_tx) else $error("can tx drive");
  property p_tc0; fw && pwdata[5:4] == 2'h0 |=> pad_oe[2] == timer_c_ch0_oe; endproperty
  a_tc0: assert property (p_tc0) else $error("timer pin drive");
  property p_st; fw && pwdata[5:4] == 2'h1 |=> pad_oe[2] && pad_o[2] == serial0_transmit; endproperty
  a_st: assert property (p_st) else $error("serial tx drive");
  property p_sr; fw && pwdata[7:6] == 2'h1 |=> serial0_receive == pad_i[3] && !pad_oe[3]; endproperty
  a_sr: assert property (p_sr) else $error("serial rx path");
  property p_red; $rose(presetn) && !full_variant |=> pad_oe[1:0] == 2'h0 && can_rx_data; endproperty
  a_red: assert property (p_red) else $error("reduced part pin state");
  c_od: cover property (pad_oe[1] && !pad_o[1]);
  c_red: cover property ($rose(presetn) && !full_variant);
  c_alt: cover property (fw && pwdata[7:6] == 2'h1);
endmodule
bind pcmx_top pcmx_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .full_variant, .can_tx_data, .can_rx_data, .timer_c_ch0_oe, .serial0_transmit,
  .serial0_receive, .pad_i, .pad_o, .pad_oe, .pad_pullup);
